/* File: hw/rsq_pkg.sv */
package rsq_pkg;

    // clock period of core_clk in picoseconds (200 MHz)
    localparam int unsigned CLK_PERIOD_PS = 5000;
    // internal rc clock startup time, in microseconds
    localparam int unsigned RC_START_US = 4;
    // startup wait in core_clk cycles, rounded up
    localparam int unsigned RC_START_CYC =
        (RC_START_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // normal reset hold count
    localparam int unsigned HOLD_NORMAL = 66;
    // reset hold count with the crystal oscillator enabled
    localparam int unsigned HOLD_XTAL = 5000;

    // program memory geometry
    localparam int unsigned PM_AW = 16;
    localparam int unsigned PM_DW = 8;
    localparam int unsigned PM_SIZE_DEF = 8192;
    // start vector bytes: high byte first, then low byte
    localparam logic [PM_AW-1:0] VEC_ADDR_HI = 16'h0002;
    localparam logic [PM_AW-1:0] VEC_ADDR_LO = 16'h0003;
    // value read back from unimplemented program memory
    localparam logic [PM_DW-1:0] UNIMPL_DATA = 8'hff;

    // system clock select codes
    localparam logic [1:0] SYSCLK_RC = 2'h0;

    // sequencer states, one-hot
    typedef enum logic [6:0] {
        ST_WAIT_SUPPLY = 7'h01,
        ST_RC_START = 7'h02,
        ST_HOLD = 7'h04,
        ST_PIN_WAIT = 7'h08,
        ST_VEC_HI = 7'h10,
        ST_VEC_LO = 7'h20,
        ST_RUN = 7'h40
    } rsq_state_e;

endpackage

/* File: hw/rsq_pm_if.sv */
`timescale 1ns/10ps
`default_nettype none

// program memory request path between sequencer and memory guard
interface rsq_pm_if
    import rsq_pkg::*;
();
    logic [PM_AW-1:0] addr;
    logic rd;
    logic wr;
    logic [PM_DW-1:0] wdata;
    logic [PM_DW-1:0] rdata;
    logic rvalid;

    modport requester
    (
        output addr, rd, wr, wdata,
        input rdata, rvalid
    );
    modport server
    (
        input addr, rd, wr, wdata,
        output rdata, rvalid
    );
endinterface

`default_nettype wire

/* File: hw/rsq_pm_guard.sv */
`timescale 1ns/10ps
`default_nettype none

// guards program memory: blocks out-of-range writes, fakes out-of-range reads
module rsq_pm_guard
    import rsq_pkg::*;
#(
    parameter int unsigned PM_SIZE = PM_SIZE_DEF
)
(
    input wire logic core_clk,
    input wire logic srst,
    rsq_pm_if.server req,
    output logic [PM_AW-1:0] flash_addr,
    output logic flash_rd,
    output logic flash_wr,
    output logic [PM_DW-1:0] flash_wdata,
    input wire logic [PM_DW-1:0] flash_rdata
);

    // whole state of the guard
    typedef struct packed {
        logic f_rd;
        logic f_wr;
        logic [PM_AW-1:0] f_addr;
        logic [PM_DW-1:0] f_wdata;
        logic s1_rd;
        logic s1_unimpl;
        logic s2_rd;
        logic s2_unimpl;
        logic [PM_DW-1:0] rdata;
        logic rvalid;
    } rsq_guard_s;

    rsq_guard_s q;
    rsq_guard_s next_q;
    logic in_range;

    // address decode against the implemented size
    assign in_range = {1'b0, req.addr} < (PM_AW+1)'(PM_SIZE);

    // next-state logic
    always_comb
    begin
        next_q = q;
        next_q.f_wr = req.wr & in_range;
        next_q.f_rd = req.rd & in_range;
        next_q.f_addr = req.addr;
        next_q.f_wdata = req.wdata;
        // pipeline keeps both paths at equal latency
        next_q.s1_rd = req.rd;
        next_q.s1_unimpl = ~in_range;
        next_q.s2_rd = q.s1_rd;
        next_q.s2_unimpl = q.s1_unimpl;
        next_q.rvalid = q.s2_rd;
        if (q.s2_unimpl)
        begin
            next_q.rdata = UNIMPL_DATA;
        end
        else if (q.s2_rd)
        begin
            next_q.rdata = flash_rdata;
        end
    end

    // state register
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            q <= '0;
        end
        else
        begin
            q <= next_q;
        end
    end

    assign flash_addr = q.f_addr;
    assign flash_rd = q.f_rd;
    assign flash_wr = q.f_wr;
    assign flash_wdata = q.f_wdata;
    assign req.rdata = q.rdata;
    assign req.rvalid = q.rvalid;

endmodule

`default_nettype wire

/* File: hw/rsq_seq.sv */
`timescale 1ns/10ps
`default_nettype none

module rsq_seq
    import rsq_pkg::*;
#(
    parameter int unsigned HOLD_XTAL_CYC = HOLD_XTAL,
    parameter int unsigned HOLD_NORM_CYC = HOLD_NORMAL,
    parameter int unsigned PM_SIZE = PM_SIZE_DEF
)
(
    input wire logic core_clk,
    input wire logic srst,
    // supply above power-on threshold, asynchronous
    input wire logic supply_ok,
    // external reset pin, asynchronous, low asserts
    input wire logic reset_pin_n,
    // one-cycle system reset request from on-chip sources
    input wire logic sys_reset_req,
    // one-cycle stop-mode recovery event
    input wire logic stop_recovery,
    // crystal enable from nonvolatile option bits
    input wire logic xtal_opt,
    // software write of the oscillator select
    input wire logic osc_sel_wr,
    input wire logic [1:0] osc_sel_val,
    // core program memory port
    input wire logic [PM_AW-1:0] core_pm_addr,
    input wire logic core_pm_rd,
    input wire logic core_pm_wr,
    input wire logic [PM_DW-1:0] core_pm_wdata,
    output logic [PM_DW-1:0] core_pm_rdata,
    output logic core_pm_rvalid,
    // flash array port
    output logic [PM_AW-1:0] flash_addr,
    output logic flash_rd,
    output logic flash_wr,
    output logic [PM_DW-1:0] flash_wdata,
    input wire logic [PM_DW-1:0] flash_rdata,
    // reset controls
    output logic core_rst,
    output logic periph_rst,
    output logic ctrl_load_all,
    output logic ctrl_load_osc,
    output logic gpio_force_input,
    output logic xtal_osc_en,
    output logic wdt_osc_en,
    output logic [1:0] sysclk_sel,
    output logic pc_load,
    output logic [15:0] pc_value
);

    // widest count the single down-counter must hold
    localparam int unsigned CNT_MAX =
        (HOLD_XTAL_CYC > RC_START_CYC) ? HOLD_XTAL_CYC : RC_START_CYC;
    localparam int unsigned CNT_W = $clog2(CNT_MAX + 1);

    // refuse counts the sequence cannot serve
    if (HOLD_NORM_CYC < 1 || HOLD_XTAL_CYC < 1 || HOLD_NORM_CYC > CNT_MAX ||
        PM_SIZE < 4 || PM_SIZE > (1 << PM_AW))
    begin : g_bad_param
        $error("rsq_seq: unsupported parameter value");
    end

    // whole state of the sequencer
    typedef struct packed {
        logic pin_s1; // pin synchroniser, first stage
        logic pin_s2; // pin synchroniser, second stage
        logic sup_s1; // supply synchroniser, first stage
        logic sup_s2; // supply synchroniser, second stage
        rsq_state_e st; // sequence state
        logic [CNT_W-1:0] cnt; // startup / hold down-counter
        logic [7:0] vec_hi; // high byte of the start vector
        logic pm_rd; // sequencer read strobe
        logic [PM_AW-1:0] pm_addr;
        logic core_rst;
        logic periph_rst;
        logic ctrl_load_all;
        logic ctrl_load_osc;
        logic gpio_force_input;
        logic xtal_osc_en;
        logic wdt_osc_en;
        logic [1:0] sysclk_sel;
        logic pc_load;
        logic [15:0] pc_value;
    } rsq_seq_s;

    rsq_seq_s q;
    rsq_seq_s next_q;

    rsq_pm_if pm();

    logic pin_low; // synchronised pin asserted
    logic supply_low; // synchronised supply below threshold
    logic core_up; // core fetching or running
    logic enter_sys; // start of a system reset
    logic enter_smr; // start of a stop-mode recovery

    assign pin_low = ~q.pin_s2;
    assign supply_low = ~q.sup_s2;
    assign core_up = (q.st == ST_RUN) || (q.st == ST_VEC_HI) ||
        (q.st == ST_VEC_LO);
    // supply loss restarts anywhere, pin only restarts a live core
    assign enter_sys = (supply_low && q.st != ST_WAIT_SUPPLY) ||
        sys_reset_req || (pin_low && core_up);
    assign enter_smr = stop_recovery && (q.st == ST_RUN) && !enter_sys;

    // memory path: sequencer owns it until the core runs
    assign pm.addr = (q.st == ST_RUN) ? core_pm_addr : q.pm_addr;
    assign pm.rd = (q.st == ST_RUN) ? core_pm_rd : q.pm_rd;
    assign pm.wr = (q.st == ST_RUN) ? core_pm_wr : 1'b0;
    assign pm.wdata = core_pm_wdata;

    // range guard in front of the flash array
    rsq_pm_guard #(
        .PM_SIZE(PM_SIZE)
    ) u_guard (
        .core_clk(core_clk),
        .srst(srst),
        .req(pm.server),
        .flash_addr(flash_addr),
        .flash_rd(flash_rd),
        .flash_wr(flash_wr),
        .flash_wdata(flash_wdata),
        .flash_rdata(flash_rdata)
    );

    // next-state logic for the whole sequencer
    always_comb
    begin
        next_q = q;
        // two-stage synchronisers for the asynchronous inputs
        next_q.pin_s1 = reset_pin_n;
        next_q.pin_s2 = q.pin_s1;
        next_q.sup_s1 = supply_ok;
        next_q.sup_s2 = q.sup_s1;
        // strobes default low
        next_q.pm_rd = 1'b0;
        next_q.ctrl_load_all = 1'b0;
        next_q.ctrl_load_osc = 1'b0;
        next_q.pc_load = 1'b0;
        next_q.wdt_osc_en = 1'b1;
        next_q.xtal_osc_en = xtal_opt;

        if (enter_sys)
        begin
            next_q.st = ST_WAIT_SUPPLY;
            next_q.core_rst = 1'b1;
            next_q.periph_rst = 1'b1;
            next_q.ctrl_load_all = 1'b1;
            next_q.gpio_force_input = 1'b1;
            next_q.sysclk_sel = SYSCLK_RC;
        end
        else if (enter_smr)
        begin
            next_q.st = ST_RC_START;
            next_q.cnt = CNT_W'(RC_START_CYC - 1);
            next_q.core_rst = 1'b1;
            next_q.periph_rst = 1'b1;
            next_q.ctrl_load_osc = 1'b1;
            next_q.sysclk_sel = SYSCLK_RC;
        end
        else
        begin
            case (q.st)
                // hold until supply crosses the threshold
                ST_WAIT_SUPPLY:
                begin
                    if (!supply_low)
                    begin
                        next_q.st = ST_RC_START;
                        next_q.cnt = CNT_W'(RC_START_CYC - 1);
                    end
                end
                // let the internal rc clock settle
                ST_RC_START:
                begin
                    if (q.cnt == '0)
                    begin
                        next_q.st = ST_HOLD;
                        if (xtal_opt)
                        begin
                            next_q.cnt = CNT_W'(HOLD_XTAL_CYC - 1);
                        end
                        else
                        begin
                            next_q.cnt = CNT_W'(HOLD_NORM_CYC - 1);
                        end
                    end
                    else
                    begin
                        next_q.cnt = q.cnt - 1'b1;
                    end
                end
                // count the reset hold period
                ST_HOLD:
                begin
                    if (q.cnt == '0)
                    begin
                        next_q.st = ST_PIN_WAIT;
                    end
                    else
                    begin
                        next_q.cnt = q.cnt - 1'b1;
                    end
                end
                // stretch while the reset pin is held
                ST_PIN_WAIT:
                begin
                    if (!pin_low)
                    begin
                        next_q.st = ST_VEC_HI;
                        next_q.periph_rst = 1'b0;
                        next_q.gpio_force_input = 1'b0;
                        next_q.pm_rd = 1'b1;
                        next_q.pm_addr = VEC_ADDR_HI;
                    end
                end
                // wait for the vector high byte
                ST_VEC_HI:
                begin
                    if (pm.rvalid)
                    begin
                        next_q.vec_hi = pm.rdata;
                        next_q.st = ST_VEC_LO;
                        next_q.pm_rd = 1'b1;
                        next_q.pm_addr = VEC_ADDR_LO;
                    end
                end
                // wait for the low byte, then start the core
                ST_VEC_LO:
                begin
                    if (pm.rvalid)
                    begin
                        next_q.pc_value = {q.vec_hi, pm.rdata};
                        next_q.pc_load = 1'b1;
                        next_q.core_rst = 1'b0;
                        next_q.st = ST_RUN;
                    end
                end
                // core running: software may pick the clock
                ST_RUN:
                begin
                    if (osc_sel_wr)
                    begin
                        next_q.sysclk_sel = osc_sel_val;
                    end
                end
                // illegal code: back to supply wait with core and peripherals in reset, no register load
                default:
                begin
                    next_q.st = ST_WAIT_SUPPLY;
                    next_q.core_rst = 1'b1;
                    next_q.periph_rst = 1'b1;
                end
            endcase
        end
    end

    // state register, synchronous reset to constants
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            q <= '0;
            q.st <= ST_WAIT_SUPPLY;
            q.core_rst <= 1'b1;
            q.periph_rst <= 1'b1;
            q.ctrl_load_all <= 1'b1;
            q.gpio_force_input <= 1'b1;
            q.wdt_osc_en <= 1'b1;
            q.sysclk_sel <= SYSCLK_RC;
        end
        else
        begin
            q <= next_q;
        end
    end

    // outputs straight from the state flops
    assign core_rst = q.core_rst;
    assign periph_rst = q.periph_rst;
    assign ctrl_load_all = q.ctrl_load_all;
    assign ctrl_load_osc = q.ctrl_load_osc;
    assign gpio_force_input = q.gpio_force_input;
    assign xtal_osc_en = q.xtal_osc_en;
    assign wdt_osc_en = q.wdt_osc_en;
    assign sysclk_sel = q.sysclk_sel;
    assign pc_load = q.pc_load;
    assign pc_value = q.pc_value;
    // read data comes from guard flops
    assign core_pm_rdata = pm.rdata;
    assign core_pm_rvalid = pm.rvalid;

endmodule

`default_nettype wire

/* File: test/rsq_flash_model.sv */
`timescale 1ns/10ps
`default_nettype none

// flash array behind the memory guard; data follows a read by one cycle
module rsq_flash_model
    import rsq_pkg::*;
(
    input wire logic core_clk,
    input wire logic [PM_AW-1:0] flash_addr,
    input wire logic flash_rd,
    input wire logic flash_wr,
    input wire logic [PM_DW-1:0] flash_wdata,
    output logic [PM_DW-1:0] flash_rdata
);
    // array contents, seeded with a known pattern
    logic [PM_DW-1:0] mem [PM_SIZE_DEF];
    // byte of the last read and its valid cycle
    logic [PM_DW-1:0] data_q = 8'h00;
    logic rd_q = 1'b0;

    // seed every byte with its address folded with a constant
    initial
    begin
        for (int i = 0; i < PM_SIZE_DEF; i++)
        begin
            mem[i] = 8'(i) ^ 8'h5a;
        end
    end

    // accept writes and launch reads at the clock edge
    always @(posedge core_clk)
    begin
        if (flash_wr)
        begin
            mem[flash_addr[12:0]] <= flash_wdata;
        end
        rd_q <= flash_rd;
        if (flash_rd)
        begin
            data_q <= mem[flash_addr[12:0]];
        end
    end

    // outside the data cycle the bus shows the inverse, never a stale byte
    assign flash_rdata = rd_q ? data_q : ~data_q;
endmodule

`default_nettype wire

/* File: test/rsq_seq_properties.sv */
`timescale 1ns/10ps
`default_nettype none

// watches reset sequencing and the memory guard at the top ports
module rsq_seq_properties
    import rsq_pkg::*;
#(
    parameter int unsigned PM_SIZE = PM_SIZE_DEF
)
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic xtal_opt,
    input wire logic [PM_AW-1:0] core_pm_addr,
    input wire logic core_pm_rd,
    input wire logic [PM_DW-1:0] core_pm_rdata,
    input wire logic core_pm_rvalid,
    input wire logic [PM_AW-1:0] flash_addr,
    input wire logic flash_rd,
    input wire logic flash_wr,
    input wire logic core_rst,
    input wire logic periph_rst,
    input wire logic ctrl_load_all,
    input wire logic ctrl_load_osc,
    input wire logic gpio_force_input,
    input wire logic xtal_osc_en,
    input wire logic wdt_osc_en,
    input wire logic [1:0] sysclk_sel,
    input wire logic pc_load
);
    // one clock domain, reset disables every check
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    a_vector_hi_fetch:
        assert property ($fell(periph_rst) |-> ##[0:2]
            (flash_rd && flash_addr == VEC_ADDR_HI))
        else $error("vector high byte not fetched after release");
    a_vector_lo_fetch:
        assert property ((core_rst && flash_rd && flash_addr == VEC_ADDR_HI)
            |-> ##4 (flash_rd && flash_addr == VEC_ADDR_LO))
        else $error("vector low byte not fetched four cycles later");
    a_pc_after_release:
        assert property ($fell(periph_rst) |-> ##8 (pc_load && !core_rst))
        else $error("pc not loaded eight cycles after release");
    a_pc_with_start:
        assert property (pc_load |-> $fell(core_rst))
        else $error("pc load not aligned with core release");
    a_core_held:
        assert property (periph_rst |-> core_rst)
        else $error("core running while peripherals in reset");
    a_gpio_in_reset:
        assert property (gpio_force_input |-> periph_rst)
        else $error("gpio forced outside reset");
    a_osc_running:
        assert property (!$past(srst) |-> wdt_osc_en
            && xtal_osc_en == $past(xtal_opt))
        else $error("oscillator enable dropped");
    a_sysclk_rc:
        assert property (pc_load |-> sysclk_sel == SYSCLK_RC)
        else $error("system clock not rc at core start");
    a_load_all_core:
        assert property (ctrl_load_all |-> core_rst)
        else $error("register load outside reset");
    a_load_osc_only:
        assert property (ctrl_load_osc |-> core_rst && !ctrl_load_all)
        else $error("stop recovery load wrong");
    a_no_high_write:
        assert property (flash_wr |-> flash_addr < PM_SIZE)
        else $error("write beyond memory reached flash");
    a_unimpl_read_ff:
        assert property ((core_pm_rd && !core_rst && core_pm_addr >= PM_SIZE)
            |-> ##3 (core_pm_rvalid && core_pm_rdata == UNIMPL_DATA))
        else $error("unimplemented read did not return ff");
endmodule

bind rsq_seq rsq_seq_properties #(.PM_SIZE(PM_SIZE)) u_props (
    .core_clk(core_clk), .srst(srst), .xtal_opt(xtal_opt),
    .core_pm_addr(core_pm_addr), .core_pm_rd(core_pm_rd),
    .core_pm_rdata(core_pm_rdata), .core_pm_rvalid(core_pm_rvalid),
    .flash_addr(flash_addr), .flash_rd(flash_rd), .flash_wr(flash_wr),
    .core_rst(core_rst), .periph_rst(periph_rst),
    .ctrl_load_all(ctrl_load_all), .ctrl_load_osc(ctrl_load_osc),
    .gpio_force_input(gpio_force_input), .xtal_osc_en(xtal_osc_en),
    .wdt_osc_en(wdt_osc_en), .sysclk_sel(sysclk_sel), .pc_load(pc_load));

`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/10ps
`default_nettype none

module tb
    import rsq_pkg::*;
;
    // shortened crystal hold and the boot window around a hold
    localparam int unsigned XCYC = 20;
    localparam int unsigned WMIN = RC_START_CYC + 3;
    localparam int unsigned WMAX = RC_START_CYC + 14;
    // one memory access and the byte it should return
    typedef struct {
        logic wr;
        logic [15:0] addr;
        logic [7:0] data;
    } rsq_row_s;
    rsq_row_s rows [7] = '{'{1'b1, 16'h0100, 8'ha5},
        '{1'b0, 16'h0100, 8'ha5},
        '{1'b0, 16'h1fff, 8'ha5}, '{1'b1, 16'h2005, 8'h00},
        '{1'b0, 16'h0005, 8'h5f}, '{1'b0, 16'h2005, 8'hff},
        '{1'b0, 16'hffff, 8'hff}};
    logic core_clk = 1'b0;
    logic srst, supply_ok, reset_pin_n, sys_reset_req, stop_recovery, xtal_opt;
    logic osc_sel_wr, core_pm_rd, core_pm_wr, core_pm_rvalid;
    logic flash_rd, flash_wr;
    logic core_rst, periph_rst, ctrl_load_all, ctrl_load_osc, gpio_force_input;
    logic xtal_osc_en, wdt_osc_en, pc_load;
    logic [1:0] osc_sel_val, sysclk_sel;
    logic [PM_AW-1:0] core_pm_addr, flash_addr;
    logic [PM_DW-1:0] core_pm_wdata, core_pm_rdata, flash_wdata, flash_rdata;
    logic [PM_DW-1:0] got;
    logic [15:0] pc_value;
    int bad_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int n_all = 0;
    int n_osc = 0;
    int lat_n, lat_x, lat_s;

    rsq_seq #(.HOLD_XTAL_CYC(XCYC)) u_dut (.core_clk(core_clk), .srst(srst),
        .supply_ok(supply_ok), .reset_pin_n(reset_pin_n),
        .sys_reset_req(sys_reset_req), .stop_recovery(stop_recovery),
        .xtal_opt(xtal_opt), .osc_sel_wr(osc_sel_wr),
        .osc_sel_val(osc_sel_val),
        .core_pm_addr(core_pm_addr), .core_pm_rd(core_pm_rd),
        .core_pm_wr(core_pm_wr), .core_pm_wdata(core_pm_wdata),
        .core_pm_rdata(core_pm_rdata), .core_pm_rvalid(core_pm_rvalid),
        .flash_addr(flash_addr), .flash_rd(flash_rd), .flash_wr(flash_wr),
        .flash_wdata(flash_wdata), .flash_rdata(flash_rdata),
        .core_rst(core_rst), .periph_rst(periph_rst),
        .ctrl_load_all(ctrl_load_all), .ctrl_load_osc(ctrl_load_osc),
        .gpio_force_input(gpio_force_input), .xtal_osc_en(xtal_osc_en),
        .wdt_osc_en(wdt_osc_en), .sysclk_sel(sysclk_sel), .pc_load(pc_load),
        .pc_value(pc_value));
    rsq_flash_model u_flash (.core_clk(core_clk), .flash_addr(flash_addr),
        .flash_rd(flash_rd), .flash_wr(flash_wr), .flash_wdata(flash_wdata),
        .flash_rdata(flash_rdata));

    // free-running 200 MHz clock
    always #2.5 core_clk = ~core_clk;

    // count load pulses and cut a hang short
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        n_all <= n_all + int'(ctrl_load_all === 1'b1);
        n_osc <= n_osc + int'(ctrl_load_osc === 1'b1);
        if (cyc == 20000)
        begin
            bad_count = bad_count + 1;
            results();
        end
    end

    // compare one value and report a difference at once
    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
        input string what);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask

    // print the counts and the verdict, then stop
    task automatic results();
        $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
        begin
            $display("NO MISMATCHES");
        end
        else
        begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // cycles until the core enters and then leaves reset
    task automatic wait_run(output int n);
        n = 0;
        while (core_rst !== 1'b1 && n < 8)
        begin
            @(negedge core_clk);
            n++;
        end
        while (core_rst !== 1'b0 && n < 12000)
        begin
            @(negedge core_clk);
            n++;
        end
    endtask

    // one-cycle request on the core memory port, waits for read data
    task automatic access(input rsq_row_s r, output logic [7:0] d);
        @(negedge core_clk);
        core_pm_addr = r.addr;
        core_pm_wr = r.wr;
        core_pm_rd = !r.wr;
        core_pm_wdata = r.data;
        @(negedge core_clk);
        core_pm_rd = 1'b0;
        core_pm_wr = 1'b0;
        d = 8'h00;
        for (int i = 0; i < 6 && !r.wr; i++)
        begin
            if (core_pm_rvalid === 1'b1)
            begin
                d = core_pm_rdata;
                break;
            end
            @(negedge core_clk);
        end
    endtask

    // one-cycle pulse on a request line
    task automatic pulse(ref logic s);
        @(negedge core_clk);
        s = 1'b1;
        @(negedge core_clk);
        s = 1'b0;
    endtask

    // main sequence
    initial
    begin
        srst = 1'b1;
        {supply_ok, sys_reset_req, stop_recovery} = 3'h0;
        {xtal_opt, osc_sel_wr} = 2'h0;
        reset_pin_n = 1'b1;
        osc_sel_val = 2'h1;
        {core_pm_rd, core_pm_wr, core_pm_addr, core_pm_wdata} = 26'h000_0000;
        repeat (3) @(negedge core_clk);
        srst = 1'b0;
        check(16'(n_all > 0), 16'h0001, "no register load in reset");
        check(16'(gpio_force_input), 16'h0001, "gpio not forced");
        check(16'(wdt_osc_en), 16'h0001, "watchdog osc stopped");
        // supply still low: nothing may be timed yet
        repeat (1000) @(negedge core_clk);
        check(16'(periph_rst), 16'h0001, "released before supply");
        supply_ok = 1'b1;
        wait_run(lat_s);
        lat_s = lat_s - HOLD_NORMAL;
        check(16'(lat_s >= WMIN + 2 && lat_s <= WMAX + 2), 16'h0001,
            "power-up hold length");
        check(pc_value, 16'h5859, "start vector");
        check(16'(gpio_force_input), 16'h0000, "gpio still forced");
        foreach (rows[i])
        begin
            access(rows[i], got);
            if (!rows[i].wr)
            begin
                check(16'(got), 16'(rows[i].data), "memory read");
            end
        end
        pulse(osc_sel_wr);
        repeat (2) @(negedge core_clk);
        check(16'(sysclk_sel), 16'h0001, "clock select ignored");
        n_all = 0;
        pulse(sys_reset_req);
        wait_run(lat_n);
        check(16'(n_all > 0), 16'h0001, "no load on system reset");
        check(16'(sysclk_sel), 16'(SYSCLK_RC), "clock not rc");
        check(16'(lat_n >= WMIN + HOLD_NORMAL && lat_n <= WMAX + HOLD_NORMAL),
            16'h0001, "system reset hold length");
        xtal_opt = 1'b1;
        pulse(sys_reset_req);
        wait_run(lat_x);
        check(16'(lat_n - lat_x), 16'(HOLD_NORMAL - XCYC),
            "crystal hold");
        pulse(osc_sel_wr);
        n_all = 0;
        n_osc = 0;
        pulse(stop_recovery);
        // core already back in reset here, pins must stay as they were
        check(16'(gpio_force_input), 16'h0000, "stop touched gpio");
        wait_run(lat_s);
        check(16'(n_osc > 0 && n_all == 0), 16'h0001, "stop loads");
        check(16'(sysclk_sel), 16'(SYSCLK_RC), "stop clock not rc");
        check(16'(lat_s >= WMIN + XCYC && lat_s <= WMAX + XCYC), 16'h0001,
            "stop recovery latency");
        check(pc_value, 16'h5859, "vector after stop");
        // pin held far past the hold count keeps the device in reset
        reset_pin_n = 1'b0;
        repeat (1500) @(negedge core_clk);
        check(16'({core_rst, periph_rst}), 16'h0003, "left reset");
        check(16'(gpio_force_input), 16'h0001, "gpio free in reset");
        reset_pin_n = 1'b1;
        wait_run(lat_s);
        check(16'(lat_s <= 14), 16'h0001, "slow exit after pin");
        // supply loss while running restarts, timed again from supply good
        supply_ok = 1'b0;
        repeat (1000) @(negedge core_clk);
        check(16'({core_rst, gpio_force_input}), 16'h0003,
            "supply loss");
        supply_ok = 1'b1;
        wait_run(lat_s);
        check(16'(lat_s >= WMIN + 2 + XCYC && lat_s <= WMAX + 2 + XCYC),
            16'h0001, "supply return hold");
        results();
    end
endmodule

`default_nettype wire
